// file: src/uecj_pkg.sv
// Package: register map, field positions and encodings for the endpoint c control block
package uecj_pkg;
    // ----------------------------------------------------------------
    // Register indices (printed offsets) and byte addresses
    // ----------------------------------------------------------------
    localparam logic [9:0] UECJ_IDX_SPARE = 10'h153;
    localparam logic [9:0] UECJ_IDX_CONTROL = 10'h154;
    localparam logic [9:0] UECJ_IDX_ROUTING = 10'h155;
    // Settings block of our own choosing: max size and endpoint active
    localparam logic [9:0] UECJ_IDX_SETUP = 10'h156;
    localparam logic [11:0] UECJ_ADDR_SPARE = {UECJ_IDX_SPARE, 2'b00};
    localparam logic [11:0] UECJ_ADDR_CONTROL = {UECJ_IDX_CONTROL, 2'b00};
    localparam logic [11:0] UECJ_ADDR_ROUTING = {UECJ_IDX_ROUTING, 2'b00};
    localparam logic [11:0] UECJ_ADDR_SETUP = {UECJ_IDX_SETUP, 2'b00};
    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int UECJ_CTL_AUTO_HOLD = 7;
    localparam int UECJ_CTL_SHORT_EN = 6;
    localparam int UECJ_CTL_SHORT_OUT_DIS = 5;
    localparam int UECJ_CTL_TOGGLE_STATE = 4;
    localparam int UECJ_CTL_TOGGLE_SET = 3;
    localparam int UECJ_CTL_TOGGLE_CLR = 2;
    localparam int UECJ_CTL_HOLD = 1;
    localparam int UECJ_CTL_HALT = 0;
    localparam logic [7:0] UECJ_CTL_RESET = 8'h00;
    // ----------------------------------------------------------------
    // Routing register fields
    // ----------------------------------------------------------------
    localparam int UECJ_RT_ATA = 7;
    localparam int UECJ_RT_FLAGS = 6;
    localparam int UECJ_RT_DMA1 = 3;
    localparam int UECJ_RT_DMA0 = 2;
    localparam int UECJ_RT_CPU_RD = 1;
    localparam int UECJ_RT_CPU_WR = 0;
    localparam logic [7:0] UECJ_RT_RESET = 8'h00;
    localparam logic [7:0] UECJ_RT_WMASK = 8'hCF;
    // ----------------------------------------------------------------
    // Setup register fields: [9:3] max size, [16] endpoint active
    // ----------------------------------------------------------------
    localparam int UECJ_SU_ACTIVE = 16;
    localparam logic [6:0] UECJ_MAXSIZE_RESET = 7'h00;
    // ----------------------------------------------------------------
    // Handshake answer codes and transaction states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        UECJ_ANS_DATA = 2'b00,
        UECJ_ANS_NAK = 2'b01,
        UECJ_ANS_STALL = 2'b10,
        UECJ_ANS_IGNORE = 2'b11
    } uecj_answer_t;
    typedef enum logic [0:0] {
        UECJ_ST_IDLE = 1'b0,
        UECJ_ST_BUSY = 1'b1
    } uecj_state_t;
endpackage : uecj_pkg

// file: src/uecj_endpoint_c.sv
// Endpoint c response control, port routing and APB register file
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Auto-hold sets hold after error-free transaction
// - Short enable sends short IN, self-clears
// - Short enable with empty FIFO sends zero-length
// - Short OUT sets hold unless disabled
// - Auto-hold wins over short-OUT disable
// - Toggle state readable in control register
// - Toggle set/clear commands, clear wins
// - Hold bit answers NAK on an active endpoint while halt is not in force
// - Hold write deferred until transaction ends
// - Halt answers STALL, beats hold
// - Halt mid-transaction applies from next one
// - ATA route moves data per IDE direction
// - Flag route drives full/empty/not-empty flags
// - DMA route joins channel, its direction
// - CPU-read route feeds FIFO read ports
// - CPU-write route feeds FIFO write ports
// - DMA remaining shows bytes or free space
// - One DMA/CPU route bit; highest wins
// - Inactive endpoint ignores host accesses
// - Max size is multiple of eight
module uecj_endpoint_c
    import uecj_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial engine side
    input wire logic tokenValid,
    input wire logic tokenIsIn,
    input wire logic xferDone,
    input wire logic xferOk,
    input wire logic [10:0] rxCount,
    input wire logic [10:0] txCount,
    output logic [1:0] answerCode,
    output logic sendZeroLength,
    output logic sendShort,
    output logic toggleState,
    input wire logic toggleAdvance,
    // FIFO status of endpoint c
    input wire logic [10:0] fifoDataCount,
    input wire logic [10:0] fifoFreeCount,
    // Port direction bits of the other blocks
    input wire logic ideDir,
    input wire logic dma0Dir,
    input wire logic dma1Dir,
    // Routing outputs
    output logic ataJoin,
    output logic ataDir,
    output logic dma0Join,
    output logic dma1Join,
    output logic dma0Dirout,
    output logic dma1Dirout,
    output logic cpuReadJoin,
    output logic cpuWriteJoin,
    output logic flagsJoin,
    output logic flagFull,
    output logic flagEmpty,
    output logic flagNotEmpty,
    output logic [10:0] dma0Remaining,
    output logic [10:0] dma1Remaining
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Keep only the highest of the four exclusive route bits
    function automatic logic [3:0] keepHighest(input logic [3:0] req);
        logic [3:0] res;
        res = 4'h0;
        if (req[3]) begin
            res = 4'h8;
        end else if (req[2]) begin
            res = 4'h4;
        end else if (req[1]) begin
            res = 4'h2;
        end else if (req[0]) begin
            res = 4'h1;
        end
        return res;
    endfunction : keepHighest

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] ctl_reg;
    logic [7:0] ctl_next;
    logic [7:0] route_reg;
    logic [7:0] route_next;
    logic [6:0] maxSize_reg;
    logic [6:0] maxSize_next;
    logic active_reg;
    logic active_next;
    logic toggle_reg;
    logic toggle_next;
    logic holdPending_reg;
    logic holdPending_next;
    logic haltLatched_reg;
    logic haltLatched_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic rdWait_reg;
    logic rdWait_next;
    uecj_state_t state_reg;
    uecj_state_t state_next;

    logic busWr;
    logic busRd;
    logic [3:0] routeReq;
    logic [10:0] maxBytes;
    logic hostEvent;
    logic autoHold;

    assign busWr = psel && penable && pwrite;
    assign busRd = psel && penable && !pwrite;
    // One wait state on reads, so read data comes straight from a flop
    assign pready = pwrite || rdWait_reg;
    assign pslverr = 1'b0;
    assign prdata = rdata_reg;
    assign maxBytes = {1'b0, maxSize_reg, 3'b000};
    assign hostEvent = active_reg && xferDone;
    assign routeReq = {pwdata[UECJ_RT_DMA1], pwdata[UECJ_RT_DMA0],
                       pwdata[UECJ_RT_CPU_RD], pwdata[UECJ_RT_CPU_WR]};

    // Auto-hold events; auto-hold wins over the short-OUT disable
    always_comb begin
        autoHold = 1'b0;
        if (hostEvent && xferOk) begin
            if (ctl_reg[UECJ_CTL_AUTO_HOLD]) begin
                autoHold = 1'b1;
            end else if (!tokenIsIn && !ctl_reg[UECJ_CTL_SHORT_OUT_DIS]
                         && (rxCount < maxBytes)) begin
                autoHold = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        ctl_next = ctl_reg;
        route_next = route_reg;
        maxSize_next = maxSize_reg;
        active_next = active_reg;
        toggle_next = toggle_reg;
        holdPending_next = holdPending_reg;
        haltLatched_next = haltLatched_reg;
        state_next = state_reg;
        rdata_next = rdata_reg;
        rdWait_next = busRd && !rdWait_reg;
        case (state_reg)
            UECJ_ST_IDLE: begin
                if (active_reg && tokenValid) begin
                    state_next = UECJ_ST_BUSY;
                    haltLatched_next = ctl_reg[UECJ_CTL_HALT];
                end
            end
            UECJ_ST_BUSY: begin
                if (xferDone) begin
                    state_next = UECJ_ST_IDLE;
                end
            end
            default: begin
                state_next = UECJ_ST_IDLE;
            end
        endcase
        // Toggle advances per data transaction
        if (hostEvent && xferOk && toggleAdvance) begin
            toggle_next = !toggle_reg;
        end
        // Software writes
        if (busWr) begin
            case (paddr)
                UECJ_ADDR_CONTROL: begin
                    ctl_next[UECJ_CTL_AUTO_HOLD] = pwdata[UECJ_CTL_AUTO_HOLD];
                    ctl_next[UECJ_CTL_SHORT_EN] = pwdata[UECJ_CTL_SHORT_EN];
                    ctl_next[UECJ_CTL_SHORT_OUT_DIS] = pwdata[UECJ_CTL_SHORT_OUT_DIS];
                    ctl_next[UECJ_CTL_HALT] = pwdata[UECJ_CTL_HALT];
                    if (!pwdata[UECJ_CTL_HOLD]) begin
                        ctl_next[UECJ_CTL_HOLD] = 1'b0;
                        holdPending_next = 1'b0;
                    end else if (state_reg == UECJ_ST_BUSY && !xferDone) begin
                        holdPending_next = 1'b1;
                    end else begin
                        ctl_next[UECJ_CTL_HOLD] = 1'b1;
                    end
                    if (pwdata[UECJ_CTL_TOGGLE_CLR]) begin
                        toggle_next = 1'b0;
                    end else if (pwdata[UECJ_CTL_TOGGLE_SET]) begin
                        toggle_next = 1'b1;
                    end
                end
                UECJ_ADDR_ROUTING: begin
                    route_next = pwdata[7:0] & UECJ_RT_WMASK;
                    route_next[3:0] = keepHighest(routeReq);
                end
                UECJ_ADDR_SETUP: begin
                    maxSize_next = pwdata[9:3];
                    active_next = pwdata[UECJ_SU_ACTIVE];
                end
                default: begin
                end
            endcase
        end
        // Hardware events win over a same-cycle software write
        if (state_reg == UECJ_ST_BUSY && xferDone && holdPending_reg) begin
            ctl_next[UECJ_CTL_HOLD] = 1'b1;
            holdPending_next = 1'b0;
        end
        if (autoHold) begin
            ctl_next[UECJ_CTL_HOLD] = 1'b1;
        end
        if (hostEvent && xferOk && tokenIsIn && ctl_reg[UECJ_CTL_SHORT_EN]
            && (txCount < maxBytes)) begin
            ctl_next[UECJ_CTL_SHORT_EN] = 1'b0;
        end
        if (state_reg == UECJ_ST_BUSY && xferDone) begin
            haltLatched_next = 1'b0;
        end
        // Strobes never store state
        ctl_next[UECJ_CTL_TOGGLE_SET] = 1'b0;
        ctl_next[UECJ_CTL_TOGGLE_CLR] = 1'b0;
        ctl_next[UECJ_CTL_TOGGLE_STATE] = 1'b0;
        // Read data
        if (busRd) begin
            case (paddr)
                UECJ_ADDR_CONTROL: begin
                    rdata_next = {24'h000000, ctl_reg};
                    rdata_next[UECJ_CTL_TOGGLE_STATE] = toggle_reg;
                end
                UECJ_ADDR_ROUTING: rdata_next = {24'h000000, route_reg};
                UECJ_ADDR_SETUP: begin
                    rdata_next = 32'h00000000;
                    rdata_next[9:3] = maxSize_reg;
                    rdata_next[UECJ_SU_ACTIVE] = active_reg;
                end
                default: rdata_next = 32'h00000000;
            endcase
        end
        if (srst) begin
            ctl_next = UECJ_CTL_RESET;
            route_next = UECJ_RT_RESET;
            maxSize_next = UECJ_MAXSIZE_RESET;
            active_next = 1'b0;
            toggle_next = 1'b0;
            holdPending_next = 1'b0;
            haltLatched_next = 1'b0;
            state_next = UECJ_ST_IDLE;
            rdata_next = 32'h00000000;
            rdWait_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        ctl_reg <= ctl_next;
        route_reg <= route_next;
        maxSize_reg <= maxSize_next;
        active_reg <= active_next;
        toggle_reg <= toggle_next;
        holdPending_reg <= holdPending_next;
        haltLatched_reg <= haltLatched_next;
        state_reg <= state_next;
        rdata_reg <= rdata_next;
        rdWait_reg <= rdWait_next;
    end

    // ----------------------------------------------------------------
    // Answers to the host
    // ----------------------------------------------------------------
    // Halt set mid-transaction is not seen until the transaction ends
    logic haltNow;
    assign haltNow = (state_reg == UECJ_ST_BUSY) ? haltLatched_reg : ctl_reg[UECJ_CTL_HALT];

    always_comb begin
        if (!active_reg) begin
            answerCode = UECJ_ANS_IGNORE;
        end else if (haltNow) begin
            answerCode = UECJ_ANS_STALL;
        end else if (ctl_reg[UECJ_CTL_HOLD]) begin
            answerCode = UECJ_ANS_NAK;
        end else begin
            answerCode = UECJ_ANS_DATA;
        end
    end
    assign sendZeroLength = ctl_reg[UECJ_CTL_SHORT_EN] && (fifoDataCount == 11'h000);
    assign sendShort = ctl_reg[UECJ_CTL_SHORT_EN] && (fifoDataCount < maxBytes);
    assign toggleState = toggle_reg;

    // ----------------------------------------------------------------
    // Port routing
    // ----------------------------------------------------------------
    assign ataJoin = route_reg[UECJ_RT_ATA];
    assign ataDir = route_reg[UECJ_RT_ATA] && ideDir;
    assign dma1Join = route_reg[UECJ_RT_DMA1];
    assign dma0Join = route_reg[UECJ_RT_DMA0];
    assign dma1Dirout = route_reg[UECJ_RT_DMA1] && dma1Dir;
    assign dma0Dirout = route_reg[UECJ_RT_DMA0] && dma0Dir;
    assign cpuReadJoin = route_reg[UECJ_RT_CPU_RD];
    assign cpuWriteJoin = route_reg[UECJ_RT_CPU_WR];
    assign flagsJoin = route_reg[UECJ_RT_FLAGS];
    assign flagFull = flagsJoin && (fifoFreeCount == 11'h000);
    assign flagEmpty = flagsJoin && (fifoDataCount == 11'h000);
    assign flagNotEmpty = flagsJoin && (fifoDataCount != 11'h000);
    // Direction 1 shows bytes held, 0 shows free space
    assign dma0Remaining = !dma0Join ? 11'h000 : (dma0Dir ? fifoDataCount : fifoFreeCount);
    assign dma1Remaining = !dma1Join ? 11'h000 : (dma1Dir ? fifoDataCount : fifoFreeCount);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_auto_hold;
        @(posedge clk_sys) disable iff (srst)
        (autoHold) |=> ctl_reg[UECJ_CTL_HOLD];
    endproperty
    a_auto_hold: assert property (p_auto_hold) else $error("hold not set after transaction");

    property p_short_clear;
        @(posedge clk_sys) disable iff (srst)
        (hostEvent && xferOk && tokenIsIn && ctl_reg[UECJ_CTL_SHORT_EN] && txCount < maxBytes)
        |=> !ctl_reg[UECJ_CTL_SHORT_EN];
    endproperty
    a_short_clear: assert property (p_short_clear) else $error("short enable not cleared");

    property p_zero_len;
        @(posedge clk_sys) disable iff (srst)
        (ctl_reg[UECJ_CTL_SHORT_EN] && fifoDataCount == 11'h000) |-> sendZeroLength;
    endproperty
    a_zero_len: assert property (p_zero_len) else $error("zero length not offered");

    property p_toggle_clr;
        @(posedge clk_sys) disable iff (srst)
        (busWr && paddr == UECJ_ADDR_CONTROL && pwdata[UECJ_CTL_TOGGLE_CLR]) |=> !toggle_reg;
    endproperty
    a_toggle_clr: assert property (p_toggle_clr) else $error("toggle clear failed");

    property p_halt_wins;
        @(posedge clk_sys) disable iff (srst)
        (active_reg && haltNow) |-> answerCode == UECJ_ANS_STALL;
    endproperty
    a_halt_wins: assert property (p_halt_wins) else $error("stall not answered");

    property p_nak;
        @(posedge clk_sys) disable iff (srst)
        (active_reg && !haltNow && ctl_reg[UECJ_CTL_HOLD]) |-> answerCode == UECJ_ANS_NAK;
    endproperty
    a_nak: assert property (p_nak) else $error("nak not answered");

    property p_route_onehot;
        @(posedge clk_sys) disable iff (srst)
        $onehot0(route_reg[3:0]);
    endproperty
    a_route_onehot: assert property (p_route_onehot) else $error("several routes set");

    property p_strobe_zero;
        @(posedge clk_sys) disable iff (srst)
        ##1 (ctl_reg[UECJ_CTL_TOGGLE_SET] == 1'b0 && ctl_reg[UECJ_CTL_TOGGLE_CLR] == 1'b0);
    endproperty
    a_strobe_zero: assert property (p_strobe_zero) else $error("strobe bits stored");

    property p_inactive;
        @(posedge clk_sys) disable iff (srst)
        !active_reg |-> answerCode == UECJ_ANS_IGNORE;
    endproperty
    a_inactive: assert property (p_inactive) else $error("inactive endpoint answered");

    c_hold_deferred: cover property (@(posedge clk_sys) disable iff (srst)
        holdPending_reg ##[1:20] ctl_reg[UECJ_CTL_HOLD]);
    c_short_in: cover property (@(posedge clk_sys) disable iff (srst)
        sendShort ##[1:20] !ctl_reg[UECJ_CTL_SHORT_EN]);
    c_stall: cover property (@(posedge clk_sys) disable iff (srst)
        answerCode == UECJ_ANS_STALL);
endmodule : uecj_endpoint_c
`default_nettype wire

// file: bench/uecj_host_model.sv
// Host-side model: issues tokens and transaction ends toward the endpoint engine inputs
`timescale 1ns/10ps
`default_nettype none
module uecj_host_model (
    input wire logic clk_sys,
    output logic tokenValid,
    output logic tokenIsIn,
    output logic xferDone,
    output logic xferOk,
    output logic [10:0] rxCount,
    output logic [10:0] txCount,
    output logic toggleAdvance
);
    initial begin
        {tokenValid, xferDone} = 2'b00;
        {tokenIsIn, xferOk, toggleAdvance} = 3'b101;
        {rxCount, txCount} = {11'h555, 11'h2AA};
    end
    task automatic start(input logic isIn);
        @(posedge clk_sys);
        tokenValid <= 1'b1;
        tokenIsIn <= isIn;
        @(posedge clk_sys);
        tokenValid <= 1'b0;
    endtask : start
    // Qualifiers mean nothing outside the done pulse, so they are scrambled there
    task automatic finish(input logic ok, input logic [10:0] cnt, input int gap);
        repeat (gap + 1) @(posedge clk_sys);
        xferDone <= 1'b1;
        {xferOk, toggleAdvance} <= {ok, ok};
        {rxCount, txCount} <= {cnt, cnt};
        @(posedge clk_sys);
        xferDone <= 1'b0;
        {xferOk, toggleAdvance} <= {~ok, ~ok};
        {rxCount, txCount} <= {~cnt, ~cnt};
        tokenIsIn <= ~tokenIsIn;
    endtask : finish
endmodule : uecj_host_model
`default_nettype wire

// file: bench/usb_endpoint_c_control_join_tb_top.sv
// Self-checking bench for the endpoint c control and routing block
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_c_control_join_tb_top
    import uecj_pkg::*;
;
    logic clk_sys, srst, psel, penable, pwrite, ideDir, dma0Dir, dma1Dir, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic tokenValid, tokenIsIn, xferDone, xferOk, toggleAdvance, sendZeroLength, sendShort;
    logic [10:0] rxCount, txCount, fifoDataCount, fifoFreeCount, dma0Remaining, dma1Remaining;
    logic [1:0] answerCode;
    logic toggleState, ataJoin, ataDir, dma0Join, dma1Join, dma0Dirout, dma1Dirout;
    logic cpuReadJoin, cpuWriteJoin, flagsJoin, flagFull, flagEmpty, flagNotEmpty;
    logic mAuto, mShort, mDis, mTog, mHold, mHalt, mPend, mLatch, mActive, mIsIn, busy;
    logic [7:0] mRoute, v;
    int fail_count = 0;
    int n_checks = 0;
    int seed = 32'hd22e;
    int mMax = 64;
    logic [7:0] tCtl [9] = '{8'h00, 8'h20, 8'hA0, 8'h80, 8'h40, 8'h40, 8'h40, 8'h00, 8'h40};
    logic [8:0] tIn = 9'b101111000;
    logic [8:0] tOk = 9'b110111111;
    int tCnt [9] = '{10, 10, 64, 64, 64, 10, 10, 64, 0};

    uecj_endpoint_c DUT (
        .clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .tokenValid, .tokenIsIn, .xferDone, .xferOk, .rxCount, .txCount, .answerCode,
        .sendZeroLength, .sendShort, .toggleState, .toggleAdvance, .fifoDataCount,
        .fifoFreeCount, .ideDir, .dma0Dir, .dma1Dir, .ataJoin, .ataDir, .dma0Join, .dma1Join,
        .dma0Dirout, .dma1Dirout, .cpuReadJoin, .cpuWriteJoin, .flagsJoin, .flagFull,
        .flagEmpty, .flagNotEmpty, .dma0Remaining, .dma1Remaining
    );
    uecj_host_model host (
        .clk_sys, .tokenValid, .tokenIsIn, .xferDone, .xferOk, .rxCount, .txCount,
        .toggleAdvance
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // Bus cycles, model updates and comparisons
    // ----------------------------------------------------------------
    task automatic check_reg(input string nm, input logic [7:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== {24'h0, exp}) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check_reg
    task automatic check_port(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check_port
    // Read data is taken at the very edge where pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rdv = prdata;
        check_port("pslverr", 32'h0, {31'h0, pslverr});
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic wctl(input logic [7:0] val);
        apb(1'b1, UECJ_ADDR_CONTROL, {24'h0, val});
        {mAuto, mShort, mDis, mHalt} = {val[7:5], val[0]};
        if (val[2]) mTog = 1'b0;
        else if (val[3]) mTog = 1'b1;
        if (busy && val[1]) mPend = 1'b1;
        else mHold = val[1];
    endtask : wctl
    task automatic chkCtl();
        apb(1'b0, UECJ_ADDR_CONTROL, 32'h0);
        check_reg("control", {mAuto, mShort, mDis, mTog, 2'b00, mHold, mHalt}, rdv);
    endtask : chkCtl
    function automatic uecj_answer_t expAns();
        if (!mActive) return UECJ_ANS_IGNORE;
        if (busy ? mLatch : mHalt) return UECJ_ANS_STALL;
        if (mHold) return UECJ_ANS_NAK;
        return UECJ_ANS_DATA;
    endfunction : expAns
    task automatic chkOut();
        @(negedge clk_sys);
        check_port("answerCode", expAns(), answerCode);
        check_port("toggleState", mTog, toggleState);
    endtask : chkOut
    task automatic xbeg(input logic isIn);
        host.start(isIn);
        {busy, mLatch, mIsIn} = {1'b1, mHalt, isIn};
    endtask : xbeg
    task automatic xend(input logic ok, input logic [10:0] cnt);
        host.finish(ok, cnt, $random(seed) & 3);
        busy = 1'b0;
        if (ok) begin
            mTog = ~mTog;
            if (mAuto) mHold = 1'b1;
            else if (!mIsIn && cnt < mMax && !mDis) mHold = 1'b1;
            if (mIsIn && cnt < mMax) mShort = 1'b0;
        end
        if (mPend) mHold = 1'b1;
        mPend = 1'b0;
    endtask : xend
    task automatic chkShort(input logic z, input logic s);
        @(negedge clk_sys);
        check_port("sendZeroLength", z, sendZeroLength);
        check_port("sendShort", s, sendShort);
    endtask : chkShort
    task automatic chkRoute();
        logic [10:0] e0, e1;
        @(negedge clk_sys);
        e0 = !mRoute[2] ? 11'h0 : dma0Dir ? fifoDataCount : fifoFreeCount;
        e1 = !mRoute[3] ? 11'h0 : dma1Dir ? fifoDataCount : fifoFreeCount;
        check_port("joins", {mRoute[7], mRoute[7] & ideDir, mRoute[3:0], mRoute[2] & dma0Dir,
            mRoute[3] & dma1Dir, mRoute[6]}, {ataJoin, ataDir, dma1Join, dma0Join, cpuReadJoin,
            cpuWriteJoin, dma0Dirout, dma1Dirout, flagsJoin});
        check_port("flags", mRoute[6] ? {fifoFreeCount == 0, fifoDataCount == 0,
            fifoDataCount != 0} : 3'b000, {flagFull, flagEmpty, flagNotEmpty});
        check_port("dma0Remaining", e0, dma0Remaining);
        check_port("dma1Remaining", e1, dma1Remaining);
    endtask : chkRoute
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {4'b1000, 12'h0, 32'h0};
        {ideDir, dma0Dir, dma1Dir, fifoDataCount, fifoFreeCount} = {3'b000, 11'h0, 11'h0};
        {mAuto, mShort, mDis, mTog, mHold, mHalt, mPend, mLatch, mActive, busy} = 10'h0;
        mRoute = 8'h00;
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        chkOut();
        chkCtl();
        apb(1'b0, UECJ_ADDR_ROUTING, 32'h0);
        check_reg("routing reset", UECJ_RT_RESET, rdv);
        // Low size bits are written as ones; they must not move the size off 64
        apb(1'b1, UECJ_ADDR_SETUP, 32'h0001_0047);
        mActive = 1'b1;
        foreach (tCtl[i]) begin
            if (i < 4) begin
                wctl(i[0] ? 8'h0C : 8'h08);
                chkCtl();
            end
        end
        for (int i = 0; i < 9; i++) begin
            wctl(tCtl[i]);
            xbeg(tIn[i]);
            chkOut();
            xend(tOk[i], 11'(tCnt[i]));
            chkCtl();
            chkOut();
        end
        wctl(8'h02);
        chkOut();
        wctl(8'h00);
        xbeg(1'b1);
        wctl(8'h02);
        chkCtl();
        wctl(8'h03);
        chkOut();
        xend(1'b1, 11'd64);
        chkCtl();
        chkOut();
        wctl(8'h40);
        chkShort(1'b1, 1'b1);
        // FIFO is refilled only while short enable is written clear
        wctl(8'h00);
        fifoDataCount <= 11'd10;
        wctl(8'h40);
        chkShort(1'b0, 1'b1);
        wctl(8'h00);
        chkShort(1'b0, 1'b0);
        for (int i = 0; i < 24; i++) begin
            v = 8'($random(seed));
            apb(1'b1, UECJ_ADDR_ROUTING, {24'h0, v});
            mRoute = {v[7:6], 2'b00, v[3] ? 4'h8 : v[2] ? 4'h4 : v[1] ? 4'h2 : {3'b000, v[0]}};
            @(posedge clk_sys);
            {ideDir, dma0Dir, dma1Dir} <= 3'($random(seed));
            fifoDataCount <= (i % 3 == 0) ? 11'h0 : 11'($random(seed));
            fifoFreeCount <= (i % 4 == 1) ? 11'h0 : 11'($random(seed));
            apb(1'b0, UECJ_ADDR_ROUTING, 32'h0);
            check_reg("routing", mRoute, rdv);
            chkRoute();
        end
        apb(1'b1, UECJ_ADDR_SPARE, 32'h0000_00FF);
        apb(1'b0, UECJ_ADDR_SPARE, 32'h0);
        check_reg("spare", 8'h00, rdv);
        apb(1'b1, UECJ_ADDR_SETUP, 32'h0000_0040);
        mActive = 1'b0;
        chkOut();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        $display("[FAIL] watchdog expected finish seen timeout");
        wrap_up();
    end
endmodule : usb_endpoint_c_control_join_tb_top
`default_nettype wire
